// ---- core/sipo_consts.svh ----
// Constants for the serial-in parallel-out latch.
`ifndef SIPO_CONSTS_SVH
`define SIPO_CONSTS_SVH
`define SIPO_WIDTH 8
`define SIPO_SYNC_STAGES 2
`define SIPO_IDLE_HIGH 1'b1
`endif

// ---- core/sipo_pkg.sv ----
// Types for the serial-in parallel-out latch.
`include "sipo_consts.svh"
package sipo_pkg;
  typedef logic [`SIPO_WIDTH-1:0] stage_vec_t;
endpackage : sipo_pkg

// ---- core/pin_sync.sv ----
// Two-flop synchroniser with a combinational rising-edge flag decoded from a delay flop.
`timescale 1ns/1ps
module pin_sync
#(
  parameter logic IDLE = 1'b0
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic sync;
  logic sync_d;
  logic next_meta;
  logic next_sync;
  logic next_sync_d;

  always_comb
  begin
    next_meta   = pin;
    next_sync   = meta;
    next_sync_d = sync;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Reset to the pin's idle level so no false edge follows reset.
      meta   <= IDLE;
      sync   <= IDLE;
      sync_d <= IDLE;
    end
    else
    begin
      meta   <= next_meta;
      sync   <= next_sync;
      sync_d <= next_sync_d;
    end
  end

  assign level = sync;
  assign rise  = sync & ~sync_d;
endmodule : pin_sync

// ---- core/sipo_latch.sv ----
// Serial-in parallel-out latch with three-state outputs.
//
// Overview of operation
// - Output enable high puts all eight parallel outputs in high impedance.
// - Output enable low drives the outputs with the storage register.
// - Clear low holds every shift stage at zero regardless of clocks.
// - Shift clock rise loads serial input into stage one, shifts others.
// - Storage clock rise with clear high copies stages into storage.
// - Coinciding edges store the pre-shift contents, then shift.
// - Each output is driven high, driven low, or released.
// - Storage contents stay unchanged while new data is shifted in.
`timescale 1ns/1ps
`include "sipo_consts.svh"
module sipo_latch
#(
  parameter int WIDTH = `SIPO_WIDTH
)
(
  input  wire logic          MCLK,
  input  wire logic          SYS_RST,
  input  wire logic          SHIFT_DATA_IN,
  input  wire logic          SHIFT_CLOCK,
  input  wire logic          SHIFT_CLEAR_N,
  input  wire logic          STORE_CLOCK,
  input  wire logic          OUT_ENABLE_N,
  output logic [WIDTH-1:0]   PAR_OUT,
  output logic [WIDTH-1:0]   PAR_OE,
  output logic               CASCADE_OUT
);
  import sipo_pkg::*;

  logic             data_lvl;
  logic             clear_n_lvl;
  logic             oe_n_lvl;
  logic             shift_rise;
  logic             store_rise;
  logic [WIDTH-1:0] stages;
  logic [WIDTH-1:0] storage;
  logic [WIDTH-1:0] next_stages;
  logic [WIDTH-1:0] next_storage;
  logic [WIDTH-1:0] next_par_out;
  logic [WIDTH-1:0] next_par_oe;
  logic             next_cascade;

  pin_sync u_data  (.clk(MCLK), .rst(SYS_RST), .pin(SHIFT_DATA_IN),
                    .level(data_lvl), .rise());
  pin_sync u_shclk (.clk(MCLK), .rst(SYS_RST), .pin(SHIFT_CLOCK),
                    .level(), .rise(shift_rise));
  pin_sync #(.IDLE(`SIPO_IDLE_HIGH)) u_clr
    (.clk(MCLK), .rst(SYS_RST), .pin(SHIFT_CLEAR_N),
     .level(clear_n_lvl), .rise());
  pin_sync u_stclk (.clk(MCLK), .rst(SYS_RST), .pin(STORE_CLOCK),
                    .level(), .rise(store_rise));
  pin_sync #(.IDLE(`SIPO_IDLE_HIGH)) u_oe
    (.clk(MCLK), .rst(SYS_RST), .pin(OUT_ENABLE_N),
     .level(oe_n_lvl), .rise());

  always_comb
  begin
    next_stages  = stages;
    next_storage = storage;
    if (!clear_n_lvl)
      next_stages = '0;
    else if (shift_rise)
      next_stages = {stages[WIDTH-2:0], data_lvl};
    if (clear_n_lvl && store_rise)
      next_storage = stages;
    next_par_out = storage;
    next_par_oe  = {WIDTH{~oe_n_lvl}};
    next_cascade = stages[WIDTH-1];
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      stages      <= '0;
      storage     <= '0;
      PAR_OUT     <= '0;
      PAR_OE      <= '0;
      CASCADE_OUT <= 1'b0;
    end
    else
    begin
      stages      <= next_stages;
      storage     <= next_storage;
      PAR_OUT     <= next_par_out;
      PAR_OE      <= next_par_oe;
      CASCADE_OUT <= next_cascade;
    end
  end

  property p_release;
    @(posedge MCLK) disable iff (SYS_RST)
      oe_n_lvl |=> (PAR_OE == '0);
  endproperty
  a_release: assert property (p_release)
    else $error("Outputs not released while disabled.");

  property p_drive;
    @(posedge MCLK) disable iff (SYS_RST)
      !oe_n_lvl |=> (&PAR_OE) && (PAR_OUT == $past(storage));
  endproperty
  a_drive: assert property (p_drive)
    else $error("Outputs not driven with storage.");

  property p_clear;
    @(posedge MCLK) disable iff (SYS_RST)
      !clear_n_lvl |=> (stages == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("Stages not cleared.");

  property p_shift;
    @(posedge MCLK) disable iff (SYS_RST)
      (clear_n_lvl && shift_rise) |=>
        stages == {$past(stages[WIDTH-2:0]), $past(data_lvl)};
  endproperty
  a_shift: assert property (p_shift)
    else $error("Shift stage mismatch.");

  property p_store;
    @(posedge MCLK) disable iff (SYS_RST)
      (clear_n_lvl && store_rise) |=> storage == $past(stages);
  endproperty
  a_store: assert property (p_store)
    else $error("Storage did not capture stages.");

  property p_hold;
    @(posedge MCLK) disable iff (SYS_RST)
      !(clear_n_lvl && store_rise) |=> $stable(storage);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Storage changed without store edge.");

  sequence s_last;
    ##1 CASCADE_OUT == $past(stages[WIDTH-1]);
  endsequence
  property p_cascade;
    @(posedge MCLK) disable iff (SYS_RST)
      1'b1 |-> s_last;
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("Cascade output mismatch.");

  property p_clear_keep;
    @(posedge MCLK) disable iff (SYS_RST)
      !clear_n_lvl |=> $stable(storage);
  endproperty
  a_clear_keep: assert property (p_clear_keep)
    else $error("Clear altered storage.");

  sequence s_store_taken;
    clear_n_lvl && store_rise;
  endsequence
  sequence s_pins_show;
    ##2 PAR_OUT == $past(stages, 2);
  endsequence
  property p_copy;
    @(posedge MCLK) disable iff (SYS_RST)
      s_store_taken |-> s_pins_show;
  endproperty
  a_copy: assert property (p_copy)
    else $error("Stored stages did not reach the outputs.");

  property p_order;
    @(posedge MCLK) disable iff (SYS_RST)
      1'b1 |=> (PAR_OUT[0] == $past(storage[0])) &&
               (PAR_OUT[WIDTH-1] == $past(storage[WIDTH-1]));
  endproperty
  a_order: assert property (p_order)
    else $error("Output bit order mismatch.");

  property p_uniform;
    @(posedge MCLK) disable iff (SYS_RST)
      1'b1 |-> (PAR_OE == '0) || (PAR_OE == '1);
  endproperty
  a_uniform: assert property (p_uniform)
    else $error("Output enables split.");

  sequence s_clear_held;
    !clear_n_lvl ##1 !clear_n_lvl;
  endsequence
  property p_clear_cascade;
    @(posedge MCLK) disable iff (SYS_RST)
      s_clear_held |=> !CASCADE_OUT;
  endproperty
  a_clear_cascade: assert property (p_clear_cascade)
    else $error("Cascade output high during clear.");

  sequence s_shift_taken;
    clear_n_lvl && shift_rise;
  endsequence
  property p_shift_cascade;
    @(posedge MCLK) disable iff (SYS_RST)
      s_shift_taken |-> ##2 CASCADE_OUT == $past(stages[WIDTH-2], 2);
  endproperty
  a_shift_cascade: assert property (p_shift_cascade)
    else $error("Shifted bit missing on cascade output.");
endmodule : sipo_latch

// ---- verification/gpio_ctrl.sv ----
// Controller model that drives the latch pins.
`timescale 1ns/1ps
module gpio_ctrl
(
  input  wire logic clk,
  output logic      data,
  output logic      sclk,
  output logic      clr_n,
  output logic      rclk,
  output logic      oe_n
);
  initial
  begin
    data = 1'b0;
    sclk = 1'b0;
    clr_n = 1'b1;
    rclk = 1'b0;
    oe_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse(input logic s, input logic r);
    sclk = s;
    rclk = r;
    tick(4);
    sclk = 1'b0;
    rclk = 1'b0;
    tick(4);
  endtask : pulse
  task automatic put(input logic d);
    data = d;
    tick(4);
    pulse(1'b1, 1'b0);
    data = ~d;
    tick(1);
  endtask : put
  task automatic dim(input logic v);
    oe_n = v;
    tick(4);
  endtask : dim
  task automatic init();
    clr_n = 1'b0;
    tick(4);
    clr_n = 1'b1;
    tick(4);
    pulse(1'b0, 1'b1);
  endtask : init
endmodule : gpio_ctrl

// ---- verification/sipo_latch_bench.sv ----
// Self-checking bench for the serial-in parallel-out latch.
`timescale 1ns/1ps
module sipo_latch_bench;
  import sipo_pkg::*;
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       d, sc, cn, rc, oen, cascade;
  stage_vec_t par_out, par_oe, m_stage, m_store;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         seed = 65208;
  stage_vec_t b;
  always #5 mclk = ~mclk;
  gpio_ctrl ctl (.clk(mclk), .data(d), .sclk(sc), .clr_n(cn), .rclk(rc),
    .oe_n(oen));
  sipo_latch uut (.MCLK(mclk), .SYS_RST(sys_rst), .SHIFT_DATA_IN(d),
    .SHIFT_CLOCK(sc), .SHIFT_CLEAR_N(cn), .STORE_CLOCK(rc),
    .OUT_ENABLE_N(oen), .PAR_OUT(par_out), .PAR_OE(par_oe),
    .CASCADE_OUT(cascade));
  task automatic check(input stage_vec_t seen, input stage_vec_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic shift(input logic v);
    m_stage = {m_stage[6:0], v};
    ctl.put(v);
    check(stage_vec_t'(cascade), stage_vec_t'(m_stage[7]));
    check(par_out, m_store);
  endtask : shift
  task automatic load(input stage_vec_t v);
    for (int i = 7; i >= 0; i--)
      shift(v[i]);
    ctl.pulse(1'b0, 1'b1);
    m_store = m_stage;
    check(par_out, v);
  endtask : load
  initial
  begin
    #50000;
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    ctl.tick(4);
    ctl.init();
    m_stage = 8'h00;
    m_store = 8'h00;
    check(par_oe, 8'h00);
    ctl.dim(1'b0);
    check(par_out, 8'h00);
    check(par_oe, 8'hFF);
    repeat (4)
      load(stage_vec_t'($random(seed)));
    ctl.data = ~m_stage[0];
    ctl.tick(4);
    ctl.pulse(1'b1, 1'b1);
    m_store = m_stage;
    m_stage = {m_stage[6:0], ~m_stage[0]};
    check(par_out, m_store);
    check(stage_vec_t'(cascade), stage_vec_t'(m_stage[7]));
    ctl.clr_n = 1'b0;
    ctl.tick(4);
    ctl.put(1'b1);
    check(stage_vec_t'(cascade), 8'h00);
    ctl.pulse(1'b0, 1'b1);
    check(par_out, m_store);
    ctl.clr_n = 1'b1;
    ctl.tick(4);
    ctl.pulse(1'b0, 1'b1);
    check(par_out, 8'h00);
    m_stage = 8'h00;
    m_store = 8'h00;
    load(stage_vec_t'($random(seed)));
    sys_rst = 1'b1;
    ctl.tick(4);
    check(par_oe, 8'h00);
    check(par_out, 8'h00);
    sys_rst = 1'b0;
    m_stage = 8'h00;
    m_store = 8'h00;
    ctl.tick(4);
    check(par_oe, 8'hFF);
    check(par_out, m_store);
    check(stage_vec_t'(cascade), stage_vec_t'(m_stage[7]));
    repeat (8)
    begin
      b = stage_vec_t'($random(seed));
      ctl.dim(b[0]);
      check(par_oe, {8{~b[0]}});
    end
    ctl.dim(1'b1);
    check(par_oe, 8'h00);
    conclude();
  end
endmodule : sipo_latch_bench
